/* File: src/aze_map.svh */
/*
 Offsets of fields, reset values and timing counts of the angle zero
 programming and read-out block. Assumes a 100 MHz core clock.
*/
`ifndef AZE_MAP_SVH
`define AZE_MAP_SVH

`define AZE_CLK_MHZ 100
`define AZE_ZERO_BURN_INPUT_EN_US 300
`define AZE_ZERO_BURN_INPUT_EN_CYC (`AZE_ZERO_BURN_INPUT_EN_US * `AZE_CLK_MHZ)
`define AZE_ZAP_MIN_NS 4500
`define AZE_ZAP_MIN_CYC ((`AZE_ZAP_MIN_NS * `AZE_CLK_MHZ + 999) / 1000)
`define AZE_CNT_W 15
`define AZE_ANGLE_W 6
`define AZE_FRAME_W 8
`define AZE_FRAME_BITS 4'h8
`define AZE_FIFO_DEPTH 8
`define AZE_PULSE_ENABLE 4'h1
`define AZE_PULSE_DATA_FIRST 4'h3
`define AZE_PULSE_DATA_LAST 4'h8
`define AZE_PULSE_CONT 4'h9
`define AZE_ZERO_RST 6'h00

`endif

/* File: src/aze_pkg.sv */
/*
 Types of the angle zero programming and read-out block.
 Assumes aze_map.svh on the include path.
*/
`include "aze_map.svh"

package aze_pkg;

   typedef struct packed
   {
      logic [`AZE_ANGLE_W-1:0] angle;
      logic field_out_of_range_flag;
   } aze_meas_t;

   typedef enum logic [3:0]
   {
      AZE_PG_IDLE = 4'b0001,
      AZE_PG_ARMED = 4'b0010,
      AZE_PG_PULSES = 4'b0100,
      AZE_PG_SPARE = 4'b1000
   } aze_zero_burn_input_t;

endpackage

/* File: src/aze_top.sv */
/*
 Angle zero capture, one-time zero programming and serial read-out of a
 6-bit angle encoder, with its input synchronisers and measurement FIFO.
 Assumes the pins arrive asynchronously and the angle front end delivers
 samples on mclk with a valid/ready handshake.
*/
`timescale 1ns/1ps
`include "aze_map.svh"

module aze_sync3
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic pin,
   output logic q_r
);
   logic [2:0] s_r;

   // a change is accepted only once the last two stages agree
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s_r <= 3'h0;
         q_r <= 1'b0;
      end
      else
      begin
         s_r <= {s_r[1:0], pin};
         if (s_r[1] == s_r[2])
            q_r <= s_r[2];
      end
   end
endmodule

module aze_fifo
#(
   parameter int WIDTH = 7,
   parameter int DEPTH = 8
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid = wr_r != rd_r;
   assign out_data = mem[rd_r[AW-1:0]];

   always_ff @(posedge mclk)
   begin
      if (push)
         mem[wr_r[AW-1:0]] <= in_data;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         wr_r <= wr_r + (AW+1)'(push);
         rd_r <= rd_r + (AW+1)'(pop);
      end
   end
endmodule

module aze_top
   import aze_pkg::*;
#(
   parameter int ZERO_BURN_INPUT_EN_CYC = `AZE_ZERO_BURN_INPUT_EN_CYC
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic select_powerdown_n,
   input wire logic shift_clk,
   input wire logic zero_burn_input,
   input wire logic meas_valid,
   output logic meas_ready,
   input wire aze_meas_t meas,
   output logic data_o,
   output logic data_oe,
   output logic cont_mode_r,
   output logic zero_lock_r
);
   localparam int ZAP_MIN = `AZE_ZAP_MIN_CYC;

   logic cs_n_f;
   logic clk_f;
   logic zero_burn_input_f;
   logic cs_n_d_r;
   logic clk_d_r;
   logic zero_burn_input_d_r;
   aze_meas_t cur_r;
   aze_meas_t fifo_data;
   logic fifo_valid;
   logic [`AZE_ANGLE_W-1:0] cand_r;
   logic [`AZE_ANGLE_W-1:0] zero_r;
   logic [`AZE_FRAME_W-1:0] frame_r;
   logic [3:0] bitcnt_r;
   logic latched_r;
   logic data_r;
   logic oe_r;
   aze_zero_burn_input_t pg_r;
   aze_zero_burn_input_t pg_nxt;
   logic [`AZE_CNT_W-1:0] cnt_r;
   logic [3:0] pcnt_r;

   aze_sync3 u_cs (.mclk(mclk), .sys_rst(sys_rst),
      .pin(select_powerdown_n), .q_r(cs_n_f));
   aze_sync3 u_clk (.mclk(mclk), .sys_rst(sys_rst),
      .pin(shift_clk), .q_r(clk_f));
   aze_sync3 u_zero_burn_input (.mclk(mclk), .sys_rst(sys_rst),
      .pin(zero_burn_input), .q_r(zero_burn_input_f));

   wire cs_rise = cs_n_f && !cs_n_d_r;
   wire clk_fall = !clk_f && clk_d_r;
   wire clk_rise = clk_f && !clk_d_r;
   wire zero_burn_input_fall = !zero_burn_input_f && zero_burn_input_d_r;
   wire busy = latched_r && (bitcnt_r < `AZE_FRAME_BITS);
   wire pop = fifo_valid && !cs_n_f && !busy;
   wire relatch = cont_mode_r && (bitcnt_r >= `AZE_FRAME_BITS);
   wire latch = clk_fall && !cs_n_f && (!latched_r || relatch);
   wire shift = clk_rise && !cs_n_f && latched_r;
   wire [`AZE_ANGLE_W-1:0] rel_angle = cur_r.angle - zero_r;
   wire parity = ^{rel_angle, cur_r.field_out_of_range_flag};
   wire chain_in = cont_mode_r ? 1'b0 : zero_burn_input_f;
   wire zap_ok = zero_burn_input_fall && (cnt_r >= `AZE_CNT_W'(ZAP_MIN - 1));
   wire en_ok = zero_burn_input_fall && (cnt_r >= `AZE_CNT_W'(ZERO_BURN_INPUT_EN_CYC - 1));
   wire zap = (pg_r == AZE_PG_PULSES) && zap_ok;
   wire [3:0] pidx = pcnt_r + 4'h1;
   wire data_pulse = (pidx >= `AZE_PULSE_DATA_FIRST)
      && (pidx <= `AZE_PULSE_DATA_LAST);
   wire [2:0] zbit = 3'(`AZE_PULSE_DATA_LAST - pidx);

   aze_fifo #(.WIDTH($bits(aze_meas_t)), .DEPTH(`AZE_FIFO_DEPTH)) u_fifo
   (
      .mclk(mclk), .sys_rst(sys_rst),
      .in_valid(meas_valid), .in_ready(meas_ready), .in_data(meas),
      .out_valid(fifo_valid), .out_ready(pop), .out_data(fifo_data)
   );

   assign data_o = data_r;
   assign data_oe = oe_r;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cs_n_d_r <= 1'b0;
         clk_d_r <= 1'b0;
         zero_burn_input_d_r <= 1'b0;
      end
      else
      begin
         cs_n_d_r <= cs_n_f;
         clk_d_r <= clk_f;
         zero_burn_input_d_r <= zero_burn_input_f;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         cur_r <= '0;
      else if (pop)
         cur_r <= fifo_data;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         cand_r <= `AZE_ZERO_RST;
      else if (cs_rise)
         cand_r <= cur_r.angle;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst || cs_n_f)
      begin
         latched_r <= 1'b0;
         bitcnt_r <= 4'h0;
         frame_r <= '0;
         data_r <= 1'b0;
      end
      else if (latch)
      begin
         latched_r <= 1'b1;
         bitcnt_r <= 4'h0;
         frame_r <= {rel_angle, cur_r.field_out_of_range_flag, parity};
      end
      else if (shift)
      begin
         data_r <= frame_r[`AZE_FRAME_W-1];
         frame_r <= {frame_r[`AZE_FRAME_W-2:0], chain_in};
         if (bitcnt_r < `AZE_FRAME_BITS)
            bitcnt_r <= bitcnt_r + 4'h1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         oe_r <= 1'b0;
      else
         oe_r <= !cs_n_f;
   end

   // enable window, then pulse counting until chip select falls
   always_comb
   begin
      pg_nxt = pg_r;
      unique case (pg_r)
         AZE_PG_IDLE:
            if (cs_n_f && zero_burn_input_f)
               pg_nxt = AZE_PG_ARMED;
         AZE_PG_ARMED:
            if (!cs_n_f || (zero_burn_input_fall && !en_ok))
               pg_nxt = AZE_PG_IDLE;
            else if (en_ok)
               pg_nxt = AZE_PG_PULSES;
         AZE_PG_PULSES:
            if (!cs_n_f)
               pg_nxt = AZE_PG_IDLE;
         default:
            pg_nxt = AZE_PG_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         pg_r <= AZE_PG_IDLE;
      else
         pg_r <= pg_nxt;
   end

   // pulse width counter saturates so long enable pulses cannot wrap
   always_ff @(posedge mclk)
   begin
      if (sys_rst || !zero_burn_input_f)
         cnt_r <= '0;
      else if (cnt_r != '1)
         cnt_r <= cnt_r + `AZE_CNT_W'(1);
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst || pg_r == AZE_PG_IDLE)
         pcnt_r <= 4'h0;
      else if (pg_r == AZE_PG_ARMED && en_ok)
         pcnt_r <= `AZE_PULSE_ENABLE;
      else if (zap && pcnt_r != 4'hF)
         pcnt_r <= pidx;
   end

   // burn one bit per data pulse; locked once complete
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         zero_r <= `AZE_ZERO_RST;
         zero_lock_r <= 1'b0;
      end
      else if (zap && data_pulse && !zero_lock_r)
      begin
         zero_r[zbit] <= cand_r[zbit];
         if (pidx == `AZE_PULSE_DATA_LAST)
            zero_lock_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         cont_mode_r <= 1'b0;
      else if (zap && pidx == `AZE_PULSE_CONT)
         cont_mode_r <= 1'b1;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence cs_edge_s;
      cs_rise;
   endsequence
   sequence frame_start_s;
      latch ##1 latched_r;
   endsequence
   sequence shift_s;
      shift && !cs_n_f;
   endsequence

   capture_zero_a:
      assert property (cs_edge_s |=> cand_r == $past(cur_r.angle))
      else $error("zero candidate not captured");
   frame_load_a:
      assert property (latch |=> frame_r[7:2] == $past(rel_angle)
         && frame_r[0] == ^frame_r[7:1])
      else $error("frame not loaded with offset angle");
   shift_msb_a:
      assert property (shift_s |=> data_r == $past(frame_r[7]))
      else $error("shift order wrong");
   latch_drive_a:
      assert property (frame_start_s |-> data_oe && bitcnt_r == 4'h0)
      else $error("latched frame not driven from its first bit");
   release_pin_a:
      assert property (cs_n_f |=> !data_oe)
      else $error("data pin driven in power-down");
   cont_set_a:
      assert property (zap && pidx == 4'h9 |=> cont_mode_r)
      else $error("continuous mode not set");
   chain_block_a:
      assert property (shift && cont_mode_r && !cs_n_f |=> !frame_r[0])
      else $error("chain input used in continuous mode");
   held_value_a:
      assert property (busy |=> $stable(cur_r))
      else $error("measurement changed while shifting");
   zero_lock_a:
      assert property (zero_lock_r |=> $stable(zero_r) && zero_lock_r)
      else $error("programmed zero changed after lock");
   zap_write_a:
      assert property (zap && data_pulse && !zero_lock_r
         |=> zero_r[$past(zbit)] == cand_r[$past(zbit)])
      else $error("zap did not burn candidate bit");
endmodule

/* File: verification/aze_ctrl_model.sv */
/*
 Controller model: drives select, shift clock and burn pin, reads frames.
 Assumes aze_top sees these pins through its own mclk synchronisers.
*/
`timescale 1ns/1ps
module aze_ctrl_model
#(
   parameter int ZERO_BURN_INPUT_EN_CYC = 200
)
(
   input wire logic mclk,
   input wire logic data_o,
   output logic select_powerdown_n,
   output logic shift_clk,
   output logic zero_burn_input
);
   initial
   begin
      select_powerdown_n = 1'b1;
      shift_clk = 1'b1;
      zero_burn_input = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic set_cs(input logic v);
      @(posedge mclk);
      select_powerdown_n <= v;
      hold(v ? 200 : 2000);
   endtask

   task automatic burn(input int hi);
      @(posedge mclk);
      zero_burn_input <= 1'b1;
      hold(hi);
      zero_burn_input <= 1'b0;
      hold(100);
   endtask

   // single mode chain data, or a driven burn pin in continuous mode
   task automatic set_burn(input logic v);
      @(posedge mclk);
      zero_burn_input <= v;
      hold(10);
   endtask

   task automatic burn_sequence(input logic ninth);
      burn(ZERO_BURN_INPUT_EN_CYC + 20);
      repeat (ninth ? 8 : 7) burn(500);
   endtask

   // shift clock period
   // 80 ns link clock: faster than a real part allows, keeps runs short
   task automatic read_frame(output logic [7:0] f);
      @(posedge mclk);
      shift_clk <= 1'b0;
      hold(500);
      for (int i = 7; i >= 0; i--)
      begin
         shift_clk <= 1'b1;
         hold(6);
         f[i] = data_o;
         // clock left high after the last bit, so the next fall latches after a reselect or in continuous mode
         if (i > 0)
            shift_clk <= 1'b0;
         hold(2);
      end
   endtask

   // ninth clock of a frame: shows the bit chained in behind parity
   task automatic shift_one(output logic b);
      @(posedge mclk);
      shift_clk <= 1'b0;
      hold(2);
      shift_clk <= 1'b1;
      hold(6);
      b = data_o;
   endtask
endmodule

/* File: verification/tb.sv */
/*
 Self-checking bench of aze_top: fills the FIFO, reads frames, programs.
 Assumes aze_ctrl_model as the controller on the pin side.
*/
`timescale 1ns/1ps
module tb
   import aze_pkg::*;
;
   logic mclk;
   logic sys_rst;
   logic meas_valid;
   logic meas_ready;
   logic data_o;
   logic data_oe;
   logic cont_mode_r;
   logic zero_lock_r;
   logic select_powerdown_n;
   logic shift_clk;
   logic zero_burn_input;
   aze_meas_t meas;
   int miscompares = 0;
   int samples_checked = 0;
   logic [7:0] fr;
   logic chain_bit;

   aze_top #(.ZERO_BURN_INPUT_EN_CYC(200)) i_dut
   (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .select_powerdown_n(select_powerdown_n),
      .shift_clk(shift_clk),
      .zero_burn_input(zero_burn_input),
      .meas_valid(meas_valid),
      .meas_ready(meas_ready),
      .meas(meas),
      .data_o(data_o),
      .data_oe(data_oe),
      .cont_mode_r(cont_mode_r),
      .zero_lock_r(zero_lock_r)
   );

   aze_ctrl_model #(.ZERO_BURN_INPUT_EN_CYC(200)) i_ctrl
   (
      .mclk(mclk),
      .data_o(data_o),
      .select_powerdown_n(select_powerdown_n),
      .shift_clk(shift_clk),
      .zero_burn_input(zero_burn_input)
   );

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic tally_and_finish;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] frame(input logic [5:0] a,
      input logic n, input logic [5:0] z);
      logic [5:0] d;
      d = a - z;
      return {d, n, ^{d, n}};
   endfunction

   task automatic push(input logic [5:0] a, input logic n);
      @(posedge mclk);
      meas_valid <= 1'b1;
      meas <= {a, n};
      @(negedge mclk);
      while (meas_ready !== 1'b1)
         @(negedge mclk);
      @(posedge mclk);
      meas_valid <= 1'b0;
   endtask

   task automatic t_fill;
      for (int i = 0; i < 8; i++)
         push(6'h23 + 6'(i), 1'b0);
      @(negedge mclk);
      chk({7'h00, meas_ready}, 8'h00);
      chk({7'h00, data_oe}, 8'h00);
      i_ctrl.set_cs(1'b0);
      chk({7'h00, meas_ready}, 8'h01);
      chk({7'h00, data_oe}, 8'h01);
      i_ctrl.set_burn(1'b1);
      i_ctrl.read_frame(fr);
      chk(fr, frame(6'h2A, 1'b0, 6'h00));
      i_ctrl.shift_one(chain_bit);
      chk({7'h00, chain_bit}, 8'h01);
      i_ctrl.set_burn(1'b0);
      $display("test fill done");
   endtask

   task automatic t_zero_burn_input;
      i_ctrl.set_cs(1'b1);
      i_ctrl.burn_sequence(1'b1);
      chk({6'h00, cont_mode_r, zero_lock_r}, 8'h03);
      i_ctrl.set_cs(1'b0);
      push(6'h05, 1'b1);
      i_ctrl.read_frame(fr);
      chk(fr, frame(6'h05, 1'b1, 6'h2A));
      i_ctrl.read_frame(fr);
      chk(fr, frame(6'h05, 1'b1, 6'h2A));
      $display("test program done");
   endtask

   task automatic t_relock;
      i_ctrl.set_cs(1'b1);
      chk({7'h00, data_oe}, 8'h00);
      i_ctrl.burn_sequence(1'b0);
      chk({7'h00, zero_lock_r}, 8'h01);
      i_ctrl.set_cs(1'b0);
      i_ctrl.set_burn(1'b1);
      i_ctrl.read_frame(fr);
      chk(fr, frame(6'h05, 1'b1, 6'h2A));
      i_ctrl.set_burn(1'b0);
      $display("test relock done");
   endtask

   initial
   begin
      sys_rst = 1'b1;
      meas_valid = 1'b0;
      meas = '0;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (10) @(posedge mclk);
      t_fill();
      t_zero_burn_input();
      t_relock();
      tally_and_finish();
   end

   initial
   begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      tally_and_finish();
   end
endmodule
